// >>> veao_defines.vh
// Constants for the virtual enable and address offset block.
// Assumes inclusion by bare name; definitions only.
`ifndef VEAO_DEFINES_VH
`define VEAO_DEFINES_VH

// Register map offsets
`define VEAO_OFS_CFG 8'h2B
`define VEAO_OFS_I2C_BASE 8'h32
`define VEAO_OFS_VID_BASE 8'h33
`define VEAO_OFS_OFFSET_RB 8'hDB

// Reset values of the working registers
`define VEAO_RST_CFG 3'h7
`define VEAO_RST_I2C_BASE 7'h44
`define VEAO_RST_VID_BASE 4'h0

// Offset configuration fields
`define VEAO_CFG_EN 0
`define VEAO_CFG_APPLY_I2C 1
`define VEAO_CFG_APPLY_VID 2

// Power setting fields
`define VEAO_PS_ENABLE 0
`define VEAO_PS_RESTART 1
`define VEAO_PS_RECAL 2
`define VEAO_PS_RELOAD 3
`define VEAO_PS_CLRTEST 4

// Command codes, values arbitrary
`define VEAO_CMD_POWER 8'h0A
`define VEAO_CMD_REG_WRITE 8'h0B
`define VEAO_CMD_REG_READ 8'h0C

// Strap step codes (one step per 20 kOhm, 8 means open)
`define VEAO_STRAP_OPEN 4'h8
`define VEAO_STRAP_HIGH_STEP 4'h4
`define VEAO_STRAP_HIGH_OFS 4'h8

// Cycles to wait after reset before strap levels are trusted
`define VEAO_WARM_CYCLES 2'h3

`endif

// >>> veao_top.v
// Virtual enable power control and bus address offset logic with I2C slave.
// Assumes SCL/SDA and strap codes are asynchronous; NVM and calibration same clock.
`timescale 1ns/100ps
`include "veao_defines.vh"

// What this block does
// - Zero setting disables and stays disabled
// - Enable alone powers up, skips calibration once one has completed
// - Restart plus recalibrate cycles and recalibrates
// - Restart, reload, clear test cycles without calibration once one has completed
// - Adding recalibrate also recalibrates after reload
// - Offset zero to fifteen on both addresses
// - Config flags: enable, apply I2C, apply VID
// - Offset enabled by default, zero disables
// - Seven bit I2C base, default 68
// - Straps sensed at power-up, offset added
// - Address sum wraps modulo field range
// - Twenty kilo-ohm steps, short and open zero
// - Total offset sums both strap offsets
// - Setting bits enable restart recal reload clear
// - Offset latched at reset power-up or reload only
// - Latched offset readable at readback register
module veao_top (
    // Clock and reset
    input wire CLK,
    input wire RST,
    // I2C pins, SDA open drain
    input wire SCL_I,
    input wire SDA_I,
    output wire SDA_O,
    output reg SDA_OE,
    // Strap sense codes, resistance in 20 kOhm steps
    input wire [3:0] OFFSET_STRAP_HIGH,
    input wire [3:0] OFFSET_STRAP_LOW,
    // Non-volatile settings source
    input wire [2:0] NVM_CFG,
    input wire [6:0] NVM_I2C_BASE,
    input wire [3:0] NVM_VID_BASE,
    output reg NVM_LOAD,
    // Calibration handshake
    output reg CAL_START,
    input wire CAL_DONE,
    // Power state
    output reg VR_ACTIVE,
    output reg IN_DISABLED,
    output reg TEST_CLEAR,
    // Effective bus addresses
    output reg [6:0] I2C_ADDR,
    output reg [3:0] VID_ADDR
);

    ////////////////////////////////////////////////////////////////////////////
    // Power states
    localparam [1:0] ST_OFF = 2'b00;
    localparam [1:0] ST_LOAD = 2'b01;
    localparam [1:0] ST_CAL = 2'b10;
    localparam [1:0] ST_ON = 2'b11;

    // Decode of one strap code into its offset
    function [3:0] strap_ofs;
        input hi;
        input [3:0] code;
        begin
            if (code >= `VEAO_STRAP_OPEN) begin
                strap_ofs = 4'h0;
            end else if (hi) begin
                strap_ofs = (code >= `VEAO_STRAP_HIGH_STEP) ? `VEAO_STRAP_HIGH_OFS : 4'h0;
            end else begin
                strap_ofs = code;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers for pins and strap codes
    reg [1:0] scl_sync_ff;
    reg [1:0] sda_sync_ff;
    reg scl_d_ff; // Previous synced SCL
    reg sda_d_ff; // Previous synced SDA
    reg [3:0] strap_h1_ff, strap_h2_ff;
    reg [3:0] strap_l1_ff, strap_l2_ff;

    // Two flops per asynchronous input, plus history for edges
    always @(posedge CLK) begin
        if (RST) begin
            scl_sync_ff <= 2'b11;
            sda_sync_ff <= 2'b11;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            strap_h1_ff <= 4'h0;
            strap_h2_ff <= 4'h0;
            strap_l1_ff <= 4'h0;
            strap_l2_ff <= 4'h0;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], SCL_I};
            sda_sync_ff <= {sda_sync_ff[0], SDA_I};
            scl_d_ff <= scl_sync_ff[1];
            sda_d_ff <= sda_sync_ff[1];
            strap_h1_ff <= OFFSET_STRAP_HIGH;
            strap_h2_ff <= strap_h1_ff;
            strap_l1_ff <= OFFSET_STRAP_LOW;
            strap_l2_ff <= strap_l1_ff;
        end
    end

    wire scl_s = scl_sync_ff[1];
    wire sda_s = sda_sync_ff[1];
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire bus_stop = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // Working registers and latched offset
    reg [2:0] cfg_ff; // Offset configuration
    reg [6:0] i2c_base_ff; // I2C base address
    reg [3:0] vid_base_ff; // VID bus base address
    reg [3:0] offset_ff; // Latched strap offset

    // Read decode of the register map
    function [7:0] reg_rd;
        input [7:0] a;
        input [2:0] c;
        input [6:0] ib;
        input [3:0] vb;
        input [3:0] o;
        begin
            case (a)
                `VEAO_OFS_CFG: reg_rd = {5'h00, c};
                `VEAO_OFS_I2C_BASE: reg_rd = {1'b0, ib};
                `VEAO_OFS_VID_BASE: reg_rd = {4'h0, vb};
                `VEAO_OFS_OFFSET_RB: reg_rd = {4'h0, o};
                default: reg_rd = 8'h00;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // I2C slave
    reg [3:0] bit_cnt_ff; // 0..7 data bits, 8 ack slot, 9 ack sampled
    reg [7:0] sh_ff; // Receive shift register
    reg [7:0] tx_ff; // Transmit byte
    reg act_ff; // Addressed in this transfer
    reg rd_ff; // Transfer is a read
    reg [1:0] byte_n_ff; // Byte index, saturates at 3
    reg [7:0] cmd_ff; // Current command code
    reg [7:0] ptr_ff; // Register pointer
    reg [7:0] pwr_set_ff; // Held power setting byte
    reg pwr_pend_ff; // Setting received, waits for stop
    reg wr_stb_ff; // Register write strobe
    reg [7:0] wr_data_ff; // Register write data
    reg [7:0] wr_addr_ff; // Register write address
    reg pwr_go_ff; // Power command strobe

    wire cmd_ok = (sh_ff == `VEAO_CMD_POWER) | (sh_ff == `VEAO_CMD_REG_WRITE) |
                  (sh_ff == `VEAO_CMD_REG_READ);
    // Byte at the register pointer, loaded for each read byte
    wire [7:0] rd_byte = reg_rd(ptr_ff, cfg_ff, i2c_base_ff, vid_base_ff, offset_ff);

    // Bit engine, byte handling and acknowledge
    always @(posedge CLK) begin
        if (RST) begin
            bit_cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            tx_ff <= 8'h00;
            act_ff <= 1'b0;
            rd_ff <= 1'b0;
            byte_n_ff <= 2'h0;
            cmd_ff <= 8'h00;
            ptr_ff <= 8'h00;
            pwr_set_ff <= 8'h00;
            pwr_pend_ff <= 1'b0;
            wr_stb_ff <= 1'b0;
            wr_data_ff <= 8'h00;
            wr_addr_ff <= 8'h00;
            pwr_go_ff <= 1'b0;
            SDA_OE <= 1'b0;
        end else begin
            wr_stb_ff <= 1'b0;
            pwr_go_ff <= 1'b0;
            if (bus_start) begin
                // Start or repeated start
                bit_cnt_ff <= 4'h0;
                byte_n_ff <= 2'h0;
                act_ff <= 1'b0;
                pwr_pend_ff <= 1'b0;
                SDA_OE <= 1'b0;
            end else if (bus_stop) begin
                // Power command acts only once the stop is seen
                pwr_go_ff <= pwr_pend_ff;
                pwr_pend_ff <= 1'b0;
                act_ff <= 1'b0;
                SDA_OE <= 1'b0;
            end else if (scl_rise) begin
                if (bit_cnt_ff < 4'h8) begin
                    sh_ff <= {sh_ff[6:0], sda_s};
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end else begin
                    // Master NACK ends a read
                    if (rd_ff & sda_s) begin
                        act_ff <= 1'b0;
                    end
                    bit_cnt_ff <= 4'h9;
                end
            end else if (scl_fall) begin
                if (bit_cnt_ff == 4'h8) begin
                    // Byte complete, decide acknowledge
                    SDA_OE <= 1'b0;
                    if (byte_n_ff != 2'h3) begin
                        byte_n_ff <= byte_n_ff + 2'h1;
                    end
                    if (byte_n_ff == 2'h0) begin
                        if (sh_ff[7:1] == I2C_ADDR) begin
                            act_ff <= 1'b1;
                            rd_ff <= sh_ff[0];
                            SDA_OE <= 1'b1;
                        end
                    end else if (act_ff & rd_ff) begin
                        ptr_ff <= ptr_ff + 8'h01;
                    end else if (act_ff & (byte_n_ff == 2'h1)) begin
                        cmd_ff <= sh_ff;
                        SDA_OE <= cmd_ok;
                    end else if (act_ff & (byte_n_ff == 2'h2)) begin
                        SDA_OE <= 1'b1;
                        if (cmd_ff == `VEAO_CMD_POWER) begin
                            pwr_set_ff <= sh_ff;
                            pwr_pend_ff <= 1'b1;
                        end else begin
                            ptr_ff <= sh_ff;
                        end
                    end else if (act_ff & (cmd_ff == `VEAO_CMD_REG_WRITE)) begin
                        // Working registers stay writable in any state
                        wr_stb_ff <= 1'b1;
                        wr_addr_ff <= ptr_ff;
                        wr_data_ff <= sh_ff;
                        ptr_ff <= ptr_ff + 8'h01;
                        SDA_OE <= 1'b1;
                    end
                end else if (bit_cnt_ff == 4'h9) begin
                    // Ack slot over, start next byte
                    bit_cnt_ff <= 4'h0;
                    if (act_ff & rd_ff) begin
                        tx_ff <= rd_byte;
                        SDA_OE <= ~rd_byte[7];
                    end else begin
                        SDA_OE <= 1'b0;
                    end
                end else if (act_ff & rd_ff) begin
                    // Shift out the next read bit
                    SDA_OE <= ~tx_ff[3'h7 - bit_cnt_ff[2:0]];
                end
            end
        end
    end

    assign SDA_O = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Power sequencer and register file
    reg [1:0] st_ff; // Power state
    reg [1:0] warm_ff; // Strap settle counter
    reg cal_once_ff; // A calibration has completed
    reg fl_rl_ff; // Pending reload of NVM settings
    reg fl_tc_ff; // Pending clear of test registers
    reg fl_cal_ff; // Pending calibration

    wire ps_en = pwr_set_ff[`VEAO_PS_ENABLE];
    wire ps_rs = pwr_set_ff[`VEAO_PS_RESTART];
    wire go_up = pwr_go_ff & ((st_ff == ST_OFF) ? (ps_en | ps_rs) : ps_rs);

    // State machine, flags and working registers
    always @(posedge CLK) begin
        if (RST) begin
            st_ff <= ST_LOAD;
            warm_ff <= 2'h0;
            cal_once_ff <= 1'b0;
            fl_rl_ff <= 1'b1;
            fl_tc_ff <= 1'b1;
            fl_cal_ff <= 1'b1;
            cfg_ff <= `VEAO_RST_CFG;
            i2c_base_ff <= `VEAO_RST_I2C_BASE;
            vid_base_ff <= `VEAO_RST_VID_BASE;
            offset_ff <= 4'h0;
            NVM_LOAD <= 1'b0;
            CAL_START <= 1'b0;
            TEST_CLEAR <= 1'b0;
        end else begin
            NVM_LOAD <= 1'b0;
            CAL_START <= 1'b0;
            TEST_CLEAR <= 1'b0;
            if (warm_ff != `VEAO_WARM_CYCLES) begin
                warm_ff <= warm_ff + 2'h1;
            end
            if (wr_stb_ff) begin
                case (wr_addr_ff)
                    `VEAO_OFS_CFG: cfg_ff <= wr_data_ff[2:0];
                    `VEAO_OFS_I2C_BASE: i2c_base_ff <= wr_data_ff[6:0];
                    `VEAO_OFS_VID_BASE: vid_base_ff <= wr_data_ff[3:0];
                    default: cfg_ff <= cfg_ff;
                endcase
            end
            if (go_up) begin
                // From any state straight into power-up, without entering disabled
                st_ff <= ST_LOAD;
                fl_rl_ff <= pwr_set_ff[`VEAO_PS_RELOAD];
                fl_tc_ff <= pwr_set_ff[`VEAO_PS_CLRTEST];
                fl_cal_ff <= pwr_set_ff[`VEAO_PS_RECAL] | ~cal_once_ff;
            end else if (pwr_go_ff & ~ps_en & (st_ff != ST_OFF) & (st_ff != ST_LOAD)) begin
                st_ff <= ST_OFF;
            end else begin
                case (st_ff)
                    ST_LOAD: begin
                        if (warm_ff == `VEAO_WARM_CYCLES) begin
                            if (fl_rl_ff) begin
                                // Reload settings and relatch straps
                                cfg_ff <= NVM_CFG;
                                i2c_base_ff <= NVM_I2C_BASE;
                                vid_base_ff <= NVM_VID_BASE;
                                NVM_LOAD <= 1'b1;
                                offset_ff <= NVM_CFG[`VEAO_CFG_EN] ?
                                    strap_ofs(1'b1, strap_h2_ff) +
                                    strap_ofs(1'b0, strap_l2_ff) : 4'h0;
                            end
                            TEST_CLEAR <= fl_tc_ff;
                            CAL_START <= fl_cal_ff;
                            st_ff <= fl_cal_ff ? ST_CAL : ST_ON;
                        end
                    end
                    ST_CAL: begin
                        if (CAL_DONE) begin
                            cal_once_ff <= 1'b1;
                            st_ff <= ST_ON;
                        end
                    end
                    ST_ON: st_ff <= ST_ON;
                    default: st_ff <= ST_OFF;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Effective addresses, sums wrap in their field width
    wire use_ofs = cfg_ff[`VEAO_CFG_EN];

    // Register addresses and state outputs
    always @(posedge CLK) begin
        if (RST) begin
            I2C_ADDR <= `VEAO_RST_I2C_BASE;
            VID_ADDR <= `VEAO_RST_VID_BASE;
            VR_ACTIVE <= 1'b0;
            IN_DISABLED <= 1'b0;
        end else begin
            I2C_ADDR <= i2c_base_ff + ((use_ofs & cfg_ff[`VEAO_CFG_APPLY_I2C]) ?
                        {3'h0, offset_ff} : 7'h00);
            VID_ADDR <= vid_base_ff + ((use_ofs & cfg_ff[`VEAO_CFG_APPLY_VID]) ?
                        offset_ff : 4'h0);
            VR_ACTIVE <= (st_ff == ST_ON);
            IN_DISABLED <= (st_ff == ST_OFF);
        end
    end

endmodule // veao_top

// >>> veao_chk.sv
// Port-level checks for the power sequencer and address offset logic.
// Assumes one clock domain, CLK, with a synchronous active-high reset.
`timescale 1ns/100ps
module veao_chk (
    // Clock and reset
    input wire CLK,
    input wire RST,
    // Bus pins
    input wire SCL_I,
    input wire SDA_I,
    // Straps and memory image
    input wire [3:0] OFFSET_STRAP_HIGH,
    input wire [3:0] OFFSET_STRAP_LOW,
    input wire [2:0] NVM_CFG,
    input wire [6:0] NVM_I2C_BASE,
    input wire [3:0] NVM_VID_BASE,
    // Sequencer outputs and calibration
    input wire NVM_LOAD,
    input wire CAL_START,
    input wire CAL_DONE,
    input wire VR_ACTIVE,
    input wire IN_DISABLED,
    input wire TEST_CLEAR,
    input wire [6:0] I2C_ADDR,
    input wire [3:0] VID_ADDR
);
    // High strap adds eight for codes four to seven only
    wire [3:0] ofs_hi = (OFFSET_STRAP_HIGH[3:2] == 2'h1) ? 4'h8 : 4'h0;
    // Low strap adds its own code; open reads zero
    wire [3:0] ofs_lo = OFFSET_STRAP_LOW[3] ? 4'h0 : OFFSET_STRAP_LOW;
    // Total offset, gated by the enable flag
    wire [3:0] ofs = NVM_CFG[0] ? ofs_hi + ofs_lo : 4'h0;
    // Expected addresses after a load; sums wrap in the field
    wire [6:0] exp_i2c = NVM_I2C_BASE + (NVM_CFG[1] ? {3'h0, ofs} : 7'h00);
    wire [3:0] exp_vid = NVM_VID_BASE + (NVM_CFG[2] ? ofs : 4'h0);
    // Calibration started and not yet reported done
    reg cal_busy_ff;
    always @(posedge CLK) begin
        if (RST) begin
            cal_busy_ff <= 1'b0;
        end else if (CAL_START) begin
            cal_busy_ff <= 1'b1;
        end else if (CAL_DONE) begin
            cal_busy_ff <= 1'b0;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_i2c_sum: assert property (NVM_LOAD |-> ##[1:2] (I2C_ADDR == exp_i2c))
        else $error("I2C address is not base plus offset");
    a_vid_sum: assert property (NVM_LOAD |-> ##[1:2] (VID_ADDR == exp_vid))
        else $error("VID address is not base plus offset");
    a_off_excl: assert property (IN_DISABLED |-> !VR_ACTIVE)
        else $error("active while disabled");
    a_leave_active: assert property ($fell(VR_ACTIVE) |-> SCL_I && SDA_I)
        else $error("left operation without a finished command");
    a_leave_off: assert property ($fell(IN_DISABLED) |-> SCL_I && SDA_I)
        else $error("left disabled state without a finished command");
    a_cal_single: assert property (CAL_START |=> !CAL_START)
        else $error("calibration start longer than one cycle");
    a_cal_wait: assert property (cal_busy_ff |-> !VR_ACTIVE)
        else $error("active before calibration finished");
    a_done_active: assert property (CAL_DONE |-> ##2 VR_ACTIVE)
        else $error("not active two cycles after calibration");
    a_clear_powerup: assert property (TEST_CLEAR |-> !VR_ACTIVE && !IN_DISABLED)
        else $error("test clear outside power-up");
endmodule // veao_chk
bind veao_top veao_chk u_chk (
    .CLK(CLK), .RST(RST), .SCL_I(SCL_I), .SDA_I(SDA_I),
    .OFFSET_STRAP_HIGH(OFFSET_STRAP_HIGH), .OFFSET_STRAP_LOW(OFFSET_STRAP_LOW),
    .NVM_CFG(NVM_CFG), .NVM_I2C_BASE(NVM_I2C_BASE), .NVM_VID_BASE(NVM_VID_BASE),
    .NVM_LOAD(NVM_LOAD), .CAL_START(CAL_START), .CAL_DONE(CAL_DONE),
    .VR_ACTIVE(VR_ACTIVE), .IN_DISABLED(IN_DISABLED), .TEST_CLEAR(TEST_CLEAR),
    .I2C_ADDR(I2C_ADDR), .VID_ADDR(VID_ADDR)
);

// >>> veao_host.sv
// Bus host model: clock pin and open-drain data pull-down.
// Assumes the bench resolves the data wire and feeds it back on sda_in.
`timescale 1ns/100ps
module veao_host (
    // Timing reference and resolved data wire
    input wire clk,
    input wire sda_in,
    // Clock level, idle high, and data pull-down
    output logic scl = 1'b1,
    output logic sda_low = 1'b0
);
    // Pass n clock edges
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Start or repeated start: data falls while clock is high
    task automatic start();
        tk(3);
        sda_low <= 1'b0;
        tk(3);
        scl <= 1'b1;
        tk(3);
        sda_low <= 1'b1;
        tk(3);
        scl <= 1'b0;
    endtask
    // Stop: data rises while clock is high, then bus stands idle
    task automatic stop();
        tk(3);
        sda_low <= 1'b1;
        tk(2);
        scl <= 1'b1;
        tk(3);
        sda_low <= 1'b0;
        tk(6);
    endtask
    // Byte out MSB first, data moved mid-low, acknowledge on the ninth clock
    task automatic wb(input logic [7:0] d, output logic ack);
        logic [8:0] s;
        s = {d, 1'b1};
        for (int i = 0; i < 9; i++) begin
            tk(3);
            sda_low <= !s[8];
            s = s << 1;
            tk(2);
            scl <= 1'b1;
            tk(3);
            ack = !sda_in;
            scl <= 1'b0;
        end
    endtask
    // Byte in, then a refusal so the device lets go of the line
    task automatic rb(output logic [7:0] d);
        for (int i = 0; i < 9; i++) begin
            tk(5);
            scl <= 1'b1;
            tk(3);
            if (i < 8)
                d = {d[6:0], sda_in};
            scl <= 1'b0;
        end
    endtask
endmodule // veao_host

// >>> virtual_enable_addr_offset_test.sv
// Self-checking bench for the power sequencer and address offset block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module virtual_enable_addr_offset_test;
    // Design inputs, straps give offset eight plus three
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [3:0] OFFSET_STRAP_HIGH = 4'h5;
    logic [3:0] OFFSET_STRAP_LOW = 4'h3;
    logic [2:0] NVM_CFG = 3'h7;
    logic [6:0] NVM_I2C_BASE = 7'h44;
    logic [3:0] NVM_VID_BASE = 4'h9;
    logic CAL_DONE = 1'b0;
    // Design outputs and the open-drain data wire with pull-up
    wire SCL_I, SDA_O, SDA_OE, NVM_LOAD, CAL_START, VR_ACTIVE, IN_DISABLED, TEST_CLEAR;
    wire [6:0] I2C_ADDR;
    wire [3:0] VID_ADDR;
    wire host_low;
    wire SDA_I = !((SDA_OE && !SDA_O) || host_low);
    // Bench state
    int bad_count = 0;
    int checked = 0;
    int n_cal = 0;
    int n_nvm = 0;
    int n_clr = 0;
    logic [3:0] done_dly = 4'h0;
    logic [6:0] dev = 7'h4F;
    logic [7:0] rd;
    logic ok;
    // Rows: register, value written, value read back
    logic [23:0] rows [4] = '{24'h33_0F0F, 24'h2B_FF07, 24'hDB_000B, 24'h50_5A00};
    veao_top dut (.CLK(CLK), .RST(RST), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
        .SDA_OE(SDA_OE), .OFFSET_STRAP_HIGH(OFFSET_STRAP_HIGH),
        .OFFSET_STRAP_LOW(OFFSET_STRAP_LOW), .NVM_CFG(NVM_CFG), .NVM_I2C_BASE(NVM_I2C_BASE),
        .NVM_VID_BASE(NVM_VID_BASE), .NVM_LOAD(NVM_LOAD), .CAL_START(CAL_START),
        .CAL_DONE(CAL_DONE), .VR_ACTIVE(VR_ACTIVE), .IN_DISABLED(IN_DISABLED),
        .TEST_CLEAR(TEST_CLEAR), .I2C_ADDR(I2C_ADDR), .VID_ADDR(VID_ADDR));
    veao_host u_host (.clk(CLK), .sda_in(SDA_I), .scl(SCL_I), .sda_low(host_low));
    // 25 MHz clock
    initial forever #20 CLK = ~CLK;
    // Calibration ends five cycles after it starts; pulses are counted
    always @(posedge CLK) begin
        done_dly <= {done_dly[2:0], CAL_START};
        CAL_DONE <= done_dly[3];
        n_cal <= n_cal + CAL_START;
        n_nvm <= n_nvm + NVM_LOAD;
        n_clr <= n_clr + TEST_CLEAR;
    end
    // Count and report one comparison
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        if (g !== e)
            bad_count++;
    endtask
    // Frame: address, n bytes, optional one-byte read after a repeated start
    task automatic xfer(input logic [7:0] b0, b1, b2, input int n, input logic r);
        logic a;
        logic [23:0] q;
        q = {b0, b1, b2};
        u_host.start();
        u_host.wb({dev, 1'b0}, ok);
        for (int i = 0; i < n; i++) begin
            u_host.wb(q[23 - 8 * i -: 8], a);
            ok &= a;
        end
        if (r) begin
            u_host.start();
            u_host.wb({dev, 1'b1}, a);
            ok &= a;
            u_host.rb(rd);
        end
        u_host.stop();
        chk("ack", 8'h01, 8'(ok));
    endtask
    // Poll the active flag under a bounded count
    task automatic wait_vr(input logic v);
        int t = 0;
        while (VR_ACTIVE !== v && t < 400) begin
            @(posedge CLK);
            t++;
        end
        chk("active", 8'(v), 8'(VR_ACTIVE));
    endtask
    // Power command, then pulse counts and final state
    task automatic pw(input logic [7:0] s, input logic v, input int dc, dn, dt);
        int c = n_cal;
        int m = n_nvm;
        int t = n_clr;
        xfer(8'h0A, s, 8'h00, 2, 1'b0);
        wait_vr(1'b0);
        wait_vr(v);
        repeat (3) @(posedge CLK);
        chk("cal", 8'(dc), 8'(n_cal - c));
        chk("load", 8'(dn), 8'(n_nvm - m));
        chk("clear", 8'(dt), 8'(n_clr - t));
        chk("disabled", 8'(!v), 8'(IN_DISABLED));
        $display("test power %h finished", s);
    endtask
    // Verdict and end of run
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #1600000;
        bad_count++;
        final_report();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge CLK);
        chk("reset i2c", 8'h44, 8'(I2C_ADDR));
        chk("reset vid", 8'h00, 8'(VID_ADDR));
        @(posedge CLK);
        RST <= 1'b0;
        wait_vr(1'b1);
        chk("i2c", 8'h4F, 8'(I2C_ADDR));
        chk("vid", 8'h04, 8'(VID_ADDR));
        $display("test reset finished");
        foreach (rows[i]) begin
            xfer(8'h0B, rows[i][23:16], rows[i][15:8], 3, 1'b0);
            xfer(8'h0C, rows[i][23:16], 8'h00, 2, 1'b1);
            chk("register", rows[i][7:0], rd);
        end
        $display("test registers finished");
        u_host.start();
        u_host.wb(8'h88, ok);
        u_host.stop();
        chk("base only", 8'h00, 8'(ok));
        $display("test address match finished");
        pw(8'h00, 1'b0, 0, 0, 0);
        xfer(8'h0B, 8'h33, 8'h03, 3, 1'b0);
        pw(8'h01, 1'b1, 0, 0, 0);
        chk("vid", 8'h0E, 8'(VID_ADDR));
        OFFSET_STRAP_LOW <= 4'h7;
        pw(8'h06, 1'b1, 1, 0, 0);
        xfer(8'h0C, 8'hDB, 8'h00, 2, 1'b1);
        chk("offset", 8'h0B, rd);
        NVM_I2C_BASE <= 7'h77;
        NVM_VID_BASE <= 4'h1;
        pw(8'h1A, 1'b1, 0, 1, 1);
        dev = 7'h06;
        chk("i2c", 8'h06, 8'(I2C_ADDR));
        chk("vid", 8'h00, 8'(VID_ADDR));
        NVM_CFG <= 3'h6;
        pw(8'h1E, 1'b1, 1, 1, 1);
        dev = 7'h77;
        chk("i2c", 8'h77, 8'(I2C_ADDR));
        xfer(8'h0C, 8'hDB, 8'h00, 2, 1'b1);
        chk("offset", 8'h00, rd);
        $display("test offset readback finished");
        // Open high strap and shorted low strap both decode to zero
        NVM_CFG <= 3'h7;
        OFFSET_STRAP_HIGH <= 4'hA;
        OFFSET_STRAP_LOW <= 4'h0;
        pw(8'h1A, 1'b1, 0, 1, 1);
        chk("i2c", 8'h77, 8'(I2C_ADDR));
        chk("vid", 8'h01, 8'(VID_ADDR));
        final_report();
    end
endmodule // virtual_enable_addr_offset_test
